// file: design/charger_status_flags.sv
// Operation
// - whole status word resets to zero
// - input present bit follows input detection
// - optimizer done bit set on routine success
// - bit shows minimum voltage protection mode
// - voltage regulation bit, forward or source
// - input current limiting bit follows limiting
// - fast charge and precharge phase bits
// - source mode bit while powering input port
// - input overvoltage flag, cleared by read
// - battery overcurrent flag, cleared by read
// - input overcurrent flag, cleared by read
// - system overvoltage latch, write zero or unplug
// - system short latch, cleared by zero write
// - read-only forced latch-off flag sticks
// - source overvoltage flag, cleared by read
// - source undervoltage flag, cleared by read
`timescale 1ns/100ps
module charger_status_flags
   import charger_status_pkg::*;
(
   input wire logic mclk_i,
   input wire logic rst_n_i,
   input wire logic ce_i,
   input live_state_type live_i,
   input fault_cond_type fault_i,
   input wire logic scl_i,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe_o,
   output logic [15:0] status_o
);

   // ----------------------------------------------------------------
   // reset release
   // ----------------------------------------------------------------
   logic [1:0] rst_sync_q;
   logic rst_n;

   // async assert, release two edges later so no flop sees a runt
   // ce does not gate the release, so a reset always finishes
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rst_sync_q <= 2'b00;
      end else begin
         rst_sync_q <= {rst_sync_q[0], 1'b1};
      end
   end
   assign rst_n = rst_sync_q[1];

   // ----------------------------------------------------------------
   // live state byte
   // ----------------------------------------------------------------
   live_state_type live_q;

   // read-only, the core drives them and the bus cannot
   always_ff @(posedge mclk_i or negedge rst_n) begin
      if (!rst_n) begin
         live_q <= live_state_type'(STATUS_RESET[15:8]);
      end else if (ce_i) begin
         live_q.input_present_flag <= live_i.input_present_flag;
         live_q.optimizer_done_flag <= live_i.optimizer_done_flag;
         live_q.min_voltage_protect_active <= live_i.min_voltage_protect_active;
         live_q.voltage_regulation_active <= live_i.voltage_regulation_active;
         live_q.input_current_limit_active <= live_i.input_current_limit_active;
         live_q.fast_charge_active <= live_i.fast_charge_active;
         live_q.precharge_active <= live_i.precharge_active;
         live_q.source_mode_active <= live_i.source_mode_active;
      end
   end

   // ----------------------------------------------------------------
   // serial bus pin sampling
   // ----------------------------------------------------------------
   logic scl_q;
   logic sda_q;
   logic scl_prev_q;
   logic sda_prev_q;
   logic scl_rise;
   logic scl_fall;
   logic start_seen;
   logic stop_seen;

   // pins are synchronous; one stage plus a history for edges
   // history resets to the idle high level: no false edge after reset
   always_ff @(posedge mclk_i or negedge rst_n) begin
      if (!rst_n) begin
         scl_q <= 1'b1;
         sda_q <= 1'b1;
         scl_prev_q <= 1'b1;
         sda_prev_q <= 1'b1;
      end else if (ce_i) begin
         scl_q <= scl_i;
         sda_q <= sda_i;
         scl_prev_q <= scl_q;
         sda_prev_q <= sda_q;
      end
   end

   assign scl_rise = scl_q && !scl_prev_q;
   assign scl_fall = !scl_q && scl_prev_q;
   assign start_seen = scl_q && scl_prev_q && sda_prev_q && !sda_q;
   assign stop_seen = scl_q && scl_prev_q && !sda_prev_q && sda_q;

   // ----------------------------------------------------------------
   // bus engine
   // ----------------------------------------------------------------
   bus_state_type state_q;
   logic [3:0] bit_cnt_q;
   logic [7:0] shift_q;
   logic [7:0] ptr_q;
   logic read_dir_q;
   logic host_nack_q;
   logic [7:0] fault_q;
   logic [7:0] rd_byte;
   logic rd_load;
   logic wr_strobe;
   logic [7:0] wr_byte;

   // byte seen by the host at the current pointer
   always_comb begin
      rd_byte = UNMAPPED_READ;
      if (ptr_q == FAULT_BYTE_ADDR) begin
         rd_byte = fault_q;
      end else if (ptr_q == STATE_BYTE_ADDR) begin
         rd_byte = live_q;
      end
   end

   // a byte is loaded for sending at these two falling edges
   assign rd_load = scl_fall && ((state_q == ST_ADDR_ACK && read_dir_q)
                    || (state_q == ST_RDATA_ACK && !host_nack_q));
   // data byte complete, strobed at the fall where its acknowledge starts
   assign wr_strobe = scl_fall && state_q == ST_WDATA && bit_cnt_q == BITS_PER_BYTE;
   assign wr_byte = shift_q;

   // state, counters and shift register
   always_ff @(posedge mclk_i or negedge rst_n) begin
      if (!rst_n) begin
         state_q <= ST_IDLE;
         bit_cnt_q <= BIT_CNT_ZERO;
         shift_q <= BYTE_ZERO;
         read_dir_q <= 1'b0;
         host_nack_q <= 1'b0;
      end else if (ce_i) begin
         if (start_seen) begin
            state_q <= ST_ADDR; // repeated start too
            bit_cnt_q <= BIT_CNT_ZERO;
         end else if (stop_seen) begin
            state_q <= ST_IDLE;
         end else begin
            unique case (state_q)
               ST_IDLE: begin
                  bit_cnt_q <= BIT_CNT_ZERO;
               end
               ST_ADDR, ST_PTR, ST_WDATA: begin
                  if (scl_rise && bit_cnt_q != BITS_PER_BYTE) begin
                     shift_q <= {shift_q[6:0], sda_q};
                     bit_cnt_q <= bit_cnt_q + BIT_CNT_ONE;
                  end else if (scl_fall && bit_cnt_q == BITS_PER_BYTE) begin
                     bit_cnt_q <= BIT_CNT_ZERO;
                     if (state_q == ST_ADDR) begin
                        if (shift_q[7:1] == TARGET_ADDR) begin
                           state_q <= ST_ADDR_ACK;
                           read_dir_q <= shift_q[0];
                        end else begin
                           state_q <= ST_IDLE; // not ours, stay off the bus
                        end
                     end else if (state_q == ST_PTR) begin
                        state_q <= ST_PTR_ACK;
                     end else begin
                        state_q <= ST_WDATA_ACK;
                     end
                  end
               end
               ST_ADDR_ACK: begin
                  if (scl_fall) begin
                     if (read_dir_q) begin
                        state_q <= ST_RDATA;
                        shift_q <= rd_byte;
                        bit_cnt_q <= BIT_CNT_ZERO;
                     end else begin
                        state_q <= ST_PTR;
                     end
                  end
               end
               ST_PTR_ACK, ST_WDATA_ACK: begin
                  if (scl_fall) begin
                     state_q <= ST_WDATA;
                  end
               end
               ST_RDATA: begin
                  if (scl_fall) begin
                     if (bit_cnt_q == LAST_BIT) begin
                        state_q <= ST_RDATA_ACK;
                     end else begin
                        shift_q <= {shift_q[6:0], 1'b0};
                        bit_cnt_q <= bit_cnt_q + BIT_CNT_ONE;
                     end
                  end
               end
               ST_RDATA_ACK: begin
                  if (scl_rise) begin
                     host_nack_q <= sda_q;
                  end else if (scl_fall) begin
                     if (host_nack_q) begin
                        state_q <= ST_IDLE; // host ends the read
                     end else begin
                        state_q <= ST_RDATA;
                        shift_q <= rd_byte;
                        bit_cnt_q <= BIT_CNT_ZERO;
                     end
                  end
               end
            endcase
         end
      end
   end

   // register pointer, auto-increments after each written byte and each acknowledged read byte
   // wraps past 8'hFF; offsets outside the map read as zero
   always_ff @(posedge mclk_i or negedge rst_n) begin
      if (!rst_n) begin
         ptr_q <= FAULT_BYTE_ADDR;
      end else if (ce_i) begin
         if (scl_fall && state_q == ST_PTR && bit_cnt_q == BITS_PER_BYTE) begin
            ptr_q <= shift_q;
         end else if (wr_strobe) begin
            ptr_q <= ptr_q + 8'h01;
         end else if (scl_fall && state_q == ST_RDATA_ACK && !host_nack_q) begin
            ptr_q <= ptr_q + 8'h01;
         end
      end
   end

   // open drain: pin only pulled low, never driven high
   // moves after an scl fall, or releases at a start or stop, which are seen while the clock is high
   always_ff @(posedge mclk_i or negedge rst_n) begin
      if (!rst_n) begin
         sda_oe_o <= 1'b0;
         sda_o <= 1'b0;
      end else if (ce_i) begin
         sda_o <= 1'b0;
         if (start_seen || stop_seen) begin
            sda_oe_o <= 1'b0;
         end else if (scl_fall) begin
            if ((state_q == ST_ADDR && bit_cnt_q == BITS_PER_BYTE
                 && shift_q[7:1] == TARGET_ADDR)
                || ((state_q == ST_PTR || state_q == ST_WDATA)
                    && bit_cnt_q == BITS_PER_BYTE)) begin
               sda_oe_o <= 1'b1; // acknowledge
            end else if (rd_load) begin
               sda_oe_o <= !rd_byte[7];
            end else if (state_q == ST_RDATA && bit_cnt_q != LAST_BIT) begin
               sda_oe_o <= !shift_q[6];
            end else begin
               sda_oe_o <= 1'b0; // release for host ack or data
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // fault flags
   // ----------------------------------------------------------------
   logic rd_fault_pulse;
   logic wr_fault_pulse;
   logic [7:0] clr_vec;

   // clear-on-read acts when the fault byte is taken for sending
   assign rd_fault_pulse = rd_load && ptr_q == FAULT_BYTE_ADDR;
   assign wr_fault_pulse = wr_strobe && ptr_q == FAULT_BYTE_ADDR;

   // clear requests per bit; the high byte has no write path
   // writing one to a write-clear bit leaves it as it is
   always_comb begin
      clr_vec = {8{rd_fault_pulse}} & CLR_ON_READ_MASK;
      clr_vec = clr_vec | ({8{wr_fault_pulse}} & ~wr_byte & CLR_ON_WRITE_MASK);
      clr_vec[FLT_SYS_OV_BIT] = clr_vec[FLT_SYS_OV_BIT] || !live_q.input_present_flag;
      clr_vec[FLT_LATCHOFF_BIT] = 1'b0;
   end

   // every flag shares one cell; only the clear source differs
   // a clear that meets a live condition loses, so no fault is missed
   genvar gi;
   generate
      for (gi = 0; gi < 8; gi = gi + 1) begin : g_flag
         sticky_flag u_flag (
            .mclk_i(mclk_i),
            .rst_n_i(rst_n),
            .ce_i(ce_i),
            .set_i(fault_i[gi]),
            .clr_i(clr_vec[gi]),
            .flag_o(fault_q[gi])
         );
      end
   endgenerate

   // flop outputs straight to the core
   assign status_o = {live_q, fault_q};

endmodule

// file: design/charger_status_pkg.sv
package charger_status_pkg;

   // ----------------------------------------------------------------
   // register map
   // ----------------------------------------------------------------
   localparam logic [7:0] FAULT_BYTE_ADDR = 8'h20; // fault flags, low byte
   localparam logic [7:0] STATE_BYTE_ADDR = 8'h21; // live state, high byte
   localparam logic [15:0] STATUS_RESET = 16'h0000;
   localparam logic [7:0] BYTE_ZERO = 8'h00;
   localparam logic [7:0] UNMAPPED_READ = 8'h00;

   // ----------------------------------------------------------------
   // serial bus
   // ----------------------------------------------------------------
   // target address is arbitrary, not taken from any part
   localparam logic [6:0] TARGET_ADDR = 7'h09;
   localparam logic [3:0] BITS_PER_BYTE = 4'h8;
   localparam logic [3:0] LAST_BIT = 4'h7;
   localparam logic [3:0] BIT_CNT_ZERO = 4'h0;
   localparam logic [3:0] BIT_CNT_ONE = 4'h1;

   // ----------------------------------------------------------------
   // fault byte field positions
   // ----------------------------------------------------------------
   localparam int FLT_IN_OV_BIT = 7;
   localparam int FLT_BAT_OC_BIT = 6;
   localparam int FLT_IN_OC_BIT = 5;
   localparam int FLT_SYS_OV_BIT = 4;
   localparam int FLT_SYSTEM_SHORT_FAULT_BIT = 3;
   localparam int FLT_LATCHOFF_BIT = 2;
   localparam int FLT_SRC_OV_BIT = 1;
   localparam int FLT_SRC_UV_BIT = 0;
   localparam logic [7:0] CLR_ON_READ_MASK = 8'hE3;
   localparam logic [7:0] CLR_ON_WRITE_MASK = 8'h18;

   // live state, high byte, msb first
   typedef struct packed {
      logic input_present_flag;
      logic optimizer_done_flag;
      logic min_voltage_protect_active;
      logic voltage_regulation_active;
      logic input_current_limit_active;
      logic fast_charge_active;
      logic precharge_active;
      logic source_mode_active;
   } live_state_type;

   // fault conditions from the power stage, low byte, msb first
   typedef struct packed {
      logic input_overvoltage_fault;
      logic battery_overcurrent_fault;
      logic input_overcurrent_fault;
      logic system_overvoltage_latch;
      logic system_short_fault;
      logic forced_latchoff_fault;
      logic source_overvoltage_fault;
      logic source_undervoltage_fault;
   } fault_cond_type;

   typedef enum logic [3:0] {
      ST_IDLE,
      ST_ADDR,
      ST_ADDR_ACK,
      ST_PTR,
      ST_PTR_ACK,
      ST_WDATA,
      ST_WDATA_ACK,
      ST_RDATA,
      ST_RDATA_ACK
   } bus_state_type;

endpackage

// file: design/sticky_flag.sv
`timescale 1ns/100ps
// ----------------------------------------------------------------
// one sticky fault flag; a set always beats a clear
// ----------------------------------------------------------------
module sticky_flag (
   input wire logic mclk_i,
   input wire logic rst_n_i,
   input wire logic ce_i,
   input wire logic set_i,
   input wire logic clr_i,
   output logic flag_o
);

   // live condition keeps the flag up even during a clear
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         flag_o <= 1'b0;
      end else if (ce_i) begin
         if (set_i) begin
            flag_o <= 1'b1;
         end else if (clr_i) begin
            flag_o <= 1'b0;
         end
      end
   end

endmodule

// file: verif/charger_status_flags_props.sv
`timescale 1ns/100ps
module charger_status_flags_props
   import charger_status_pkg::*;
(
   input wire logic mclk_i,
   input wire logic rst_n_i,
   input wire logic ce_i,
   input live_state_type live_i,
   input fault_cond_type fault_i,
   input wire logic scl_i,
   input wire logic sda_i,
   input wire logic sda_o,
   input wire logic sda_oe_o,
   input wire logic [15:0] status_o
);
   logic [1:0] up_q;

   // ------------------------------------------------------------
   // settle counter
   // ------------------------------------------------------------
   // core leaves reset two edges after the pin; skip that window
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         up_q <= 2'h0;
      end else if (up_q != 2'h3) begin
         up_q <= up_q + 2'h1;
      end
   end

   // ------------------------------------------------------------
   // properties
   // ------------------------------------------------------------
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!rst_n_i);

   sequence s_ready;
      up_q == 2'h3;
   endsequence

   sequence s_unplugged;
      ce_i && !status_o[15] && !fault_i[FLT_SYS_OV_BIT];
   endsequence

   a_reset_zero: assert property (disable iff (1'b0)
      !rst_n_i |-> status_o == STATUS_RESET) else $error("status not zero in reset");
   a_live_follows: assert property (
      s_ready ##0 $past(ce_i) |-> status_o[15:8] == $past(live_i))
      else $error("state byte does not follow inputs");
   a_fault_sets: assert property (
      s_ready ##0 $past(ce_i) |-> (status_o[7:0] & $past(fault_i)) == $past(fault_i))
      else $error("fault flag missed its condition");
   a_present_holds: assert property (
      s_ready |-> (~status_o[7:0] & $past(status_o[7:0]) & $past(fault_i)) == 8'h00)
      else $error("flag dropped while fault present");
   a_latchoff_sticky: assert property (
      s_ready ##0 $past(status_o[FLT_LATCHOFF_BIT]) |-> status_o[FLT_LATCHOFF_BIT])
      else $error("latch-off flag cleared");
   a_unplug_clears: assert property (
      s_ready ##0 s_unplugged |=> !status_o[FLT_SYS_OV_BIT])
      else $error("overvoltage latch kept with no input");
   a_read_clear_time: assert property (
      s_ready ##0 ((~status_o[7:0] & $past(status_o[7:0]) & CLR_ON_READ_MASK) != 8'h00)
      |-> !scl_i) else $error("read-clear flag fell outside a byte load");
   a_ack_timing: assert property (
      s_ready ##0 $changed(sda_oe_o) |-> !scl_i && !$past(scl_i))
      else $error("data pin changed while clock high");
   a_pin_open_drain: assert property (sda_o == 1'b0) else $error("data pin driven high");
endmodule

// file: verif/serial_host_model.sv
`timescale 1ns/100ps
module serial_host_model
   import charger_status_pkg::*;
(
   input wire logic mclk_i,
   input wire logic dev_pull_i,
   output logic scl_o,
   output logic sda_o
);
   logic pull = 1'b0;

   // pull-up on the line: released reads high
   assign sda_o = ~(pull | dev_pull_i);
   initial scl_o = 1'b1;

   // ------------------------------------------------------------
   // bus primitives, six cycles per phase (four is the minimum)
   // ------------------------------------------------------------
   task automatic half();
      repeat (6) @(negedge mclk_i);
   endtask

   // also serves as repeated start from clock low
   task automatic start();
      pull = 1'b0;
      half();
      scl_o = 1'b1;
      half();
      pull = 1'b1;
      half();
      scl_o = 1'b0;
      half();
   endtask

   task automatic stop();
      pull = 1'b1;
      half();
      scl_o = 1'b1;
      half();
      pull = 1'b0;
      half();
   endtask

   // eight bits plus the acknowledge slot, msb first
   task automatic xfer(input logic [8:0] d, output logic [8:0] r);
      for (int i = 8; i >= 0; i--) begin
         pull = ~d[i];
         half();
         scl_o = 1'b1;
         half();
         r[i] = sda_o;
         scl_o = 1'b0;
         half();
      end
   endtask

   task automatic wr(input logic [6:0] ta, input logic [7:0] p, input logic [7:0] dt,
                     output logic ok);
      logic [8:0] a, b, c;
      start();
      xfer({ta, 2'b01}, a);
      xfer({p, 1'b1}, b);
      xfer({dt, 1'b1}, c);
      stop();
      ok = !a[0] && !b[0] && !c[0];
   endtask

   // single byte read, closed by a not-acknowledge
   task automatic rd(input logic [7:0] p, output logic [7:0] d, output logic ok);
      logic [8:0] a, b, c, r;
      start();
      xfer({TARGET_ADDR, 2'b01}, a);
      xfer({p, 1'b1}, b);
      start();
      xfer({TARGET_ADDR, 2'b11}, c);
      xfer({8'hFF, 1'b1}, r);
      stop();
      d = r[8:1];
      ok = !a[0] && !b[0] && !c[0];
   endtask
endmodule

// file: verif/charger_status_flags_tb_top.sv
`timescale 1ns/100ps
module charger_status_flags_tb_top
   import charger_status_pkg::*;
;
   // clock starts high so reset falls at an edge before any rising one
   logic mclk = 1'b1;
   logic rst_n = 1'b1;
   logic ce = 1'b1;
   live_state_type live = '0;
   fault_cond_type fault = '0;
   logic scl, sda, sda_oe;
   logic [15:0] status;
   int fails = 0;
   int tests_run = 0;

   charger_status_flags DUT (.mclk_i(mclk), .rst_n_i(rst_n), .ce_i(ce), .live_i(live),
      .fault_i(fault), .scl_i(scl), .sda_i(sda), .sda_o(), .sda_oe_o(sda_oe),
      .status_o(status));
   serial_host_model host (.mclk_i(mclk), .dev_pull_i(sda_oe), .scl_o(scl), .sda_o(sda));

   initial begin
      forever #12.5 mclk = ~mclk;
   end

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      tests_run++;
      if (got !== exp) begin
         $display("ERROR %s expected %h seen %h", what, exp, got);
         fails++;
      end
   endtask

   task automatic rd_chk(input logic [7:0] p, input logic [7:0] exp);
      logic [7:0] d;
      logic ok;
      host.rd(p, d, ok);
      chk("read ack", 16'h0001, {15'h0, ok});
      chk("read byte", {8'h00, exp}, {8'h00, d});
   endtask

   task automatic wr_chk(input logic [7:0] p, input logic [7:0] dt);
      logic ok;
      host.wr(TARGET_ADDR, p, dt, ok);
      chk("write ack", 16'h0001, {15'h0, ok});
   endtask

   // short fault burst, gone before the host reads
   task automatic fpulse(input logic [7:0] f);
      @(negedge mclk);
      fault = fault_cond_type'(f);
      repeat (3) @(negedge mclk);
      fault = '0;
   endtask

   task automatic test_done();
      $display("checks %0d mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   task automatic t_reset();
      chk("status", STATUS_RESET, status);
      rd_chk(FAULT_BYTE_ADDR, 8'h00);
      rd_chk(STATE_BYTE_ADDR, 8'h00);
      $display("test reset done");
   endtask

   task automatic t_live();
      for (int i = 0; i < 8; i++) begin
         live = live_state_type'(8'h01 << i);
         rd_chk(STATE_BYTE_ADDR, 8'h01 << i);
      end
      wr_chk(STATE_BYTE_ADDR, 8'hFF);
      rd_chk(STATE_BYTE_ADDR, 8'h80);
      // enable low must freeze the state byte against a changed input
      ce = 1'b0;
      live = live_state_type'(8'h41);
      repeat (4) @(negedge mclk);
      chk("frozen status", 16'h8000, status);
      ce = 1'b1;
      live = live_state_type'(8'h80);
      repeat (2) @(negedge mclk);
      chk("status after enable", 16'h8000, status);
      $display("test live done");
   endtask

   task automatic t_read_clear();
      fpulse(8'hE3);
      rd_chk(FAULT_BYTE_ADDR, 8'hE3);
      rd_chk(FAULT_BYTE_ADDR, 8'h00);
      fault = fault_cond_type'(8'hE3);
      rd_chk(FAULT_BYTE_ADDR, 8'hE3);
      rd_chk(FAULT_BYTE_ADDR, 8'hE3);
      fault = '0;
      wr_chk(FAULT_BYTE_ADDR, 8'h00);
      rd_chk(FAULT_BYTE_ADDR, 8'hE3);
      rd_chk(FAULT_BYTE_ADDR, 8'h00);
      $display("test read clear done");
   endtask

   task automatic t_write_zero();
      fpulse(8'h18);
      rd_chk(FAULT_BYTE_ADDR, 8'h18);
      fault = fault_cond_type'(8'h18);
      wr_chk(FAULT_BYTE_ADDR, 8'h00);
      rd_chk(FAULT_BYTE_ADDR, 8'h18);
      fault = '0;
      wr_chk(FAULT_BYTE_ADDR, 8'h10);
      rd_chk(FAULT_BYTE_ADDR, 8'h10);
      live = '0;
      repeat (4) @(negedge mclk);
      chk("overvoltage latch", 16'h0000, {15'h0, status[FLT_SYS_OV_BIT]});
      $display("test write zero done");
   endtask

   task automatic t_latch_and_bus();
      logic ok;
      fpulse(8'h04);
      rd_chk(FAULT_BYTE_ADDR, 8'h04);
      wr_chk(FAULT_BYTE_ADDR, 8'h00);
      rd_chk(FAULT_BYTE_ADDR, 8'h04);
      host.wr(TARGET_ADDR + 7'h01, FAULT_BYTE_ADDR, 8'h00, ok);
      chk("foreign ack", 16'h0000, {15'h0, ok});
      rd_chk(8'h30, UNMAPPED_READ);
      // mid-run reset: only reset may drop the latch-off flag
      live = live_state_type'(8'hFF);
      repeat (2) @(negedge mclk);
      rst_n = 1'b0;
      @(negedge mclk);
      chk("status in reset", STATUS_RESET, status);
      rst_n = 1'b1;
      repeat (4) @(negedge mclk);
      chk("status after reset", 16'hFF00, status);
      $display("test latch and bus done");
   endtask

   // reset goes low at the first falling edge and is held 12 cycles
   initial begin
      @(negedge mclk);
      rst_n = 1'b0;
      repeat (12) @(negedge mclk);
      rst_n = 1'b1;
      repeat (4) @(negedge mclk);
      t_reset();
      t_live();
      t_read_clear();
      t_write_zero();
      t_latch_and_bus();
      test_done();
   end

   // about 20k cycles expected; cut off at three times that
   initial begin
      repeat (60000) @(posedge mclk);
      fails++;
      test_done();
   end
endmodule

bind charger_status_flags charger_status_flags_props props (.mclk_i, .rst_n_i, .ce_i, .live_i,
   .fault_i, .scl_i, .sda_i, .sda_o, .sda_oe_o, .status_o);
